// >>> include/debp_pkg.sv
// package of constants for the data eeprom byte programming port
// assumes both link ends and the bench compile it first
package debp_pkg;
	// ----------------------------------------------------------------
	// widths and array size
	// ----------------------------------------------------------------
	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 9;
	localparam int unsigned MEM_DEPTH = 512;
	localparam int unsigned CMD_W = 1 + ADDR_W + DATA_W;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned DONE_BIT = 7;

	// ----------------------------------------------------------------
	// command byte values
	// ----------------------------------------------------------------
	localparam logic [7:0] PREFIX = 8'h75;
	localparam logic [7:0] SEL_UPPER = 8'hf1;
	localparam logic [7:0] SEL_DATA = 8'hf2;
	localparam logic [7:0] SEL_LOW = 8'hf3;
	localparam logic [7:0] LAUNCH = 8'he5;
	localparam logic [7:0] LAUNCH_WR = 8'hf1;
	localparam logic [7:0] LAUNCH_RD = 8'hf2;
	localparam logic [7:0] LAUNCH_K1 = 8'hf5;
	localparam logic [7:0] LAUNCH_K2 = 8'ha0;
	localparam logic [7:0] FILL = 8'h00;
	localparam logic [7:0] DONE_MASK = 8'h80;
	localparam logic [7:0] RESULT_RST = 8'h00;

	// ----------------------------------------------------------------
	// sequence positions
	// ----------------------------------------------------------------
	localparam logic [3:0] SEQ_FIRST = 4'h0;
	localparam logic [3:0] SEQ_AFTER_UPPER = 4'h3;
	localparam logic [3:0] SEQ_LAUNCH = 4'h9;
	localparam logic [3:0] SEQ_LAST = 4'he;
	localparam logic [2:0] LAUNCH_LAST_STEP = 3'h4;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned PULSE_MIN_NS = 1000;
	localparam int unsigned PULSE_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] WRITE_PULSES = 4'h8;
	localparam logic [2:0] WAKE_PULSES = 3'h4;
endpackage : debp_pkg

// >>> include/debp_link_if.sv
// pins between the external programmer and the data eeprom port
// assumes the programmer drives clock and data, the device answers
`timescale 1ns/1ns
interface debp_link_if;
	logic [7:0] prog_data_bus;
	logic prog_clock_pin;
	logic handshake_toggle;
	logic [7:0] result_port;

	// ----------------------------------------------------------------
	// one view for each end
	// ----------------------------------------------------------------
	modport dev (
		input prog_data_bus,
		input prog_clock_pin,
		output handshake_toggle,
		output result_port
	);
	modport prg (
		output prog_data_bus,
		output prog_clock_pin,
		input handshake_toggle,
		input result_port
	);
endinterface : debp_link_if

// >>> verilog/debp_device.sv
// device end: byte decoder, 512-byte array and write timer; also the command fifo
// assumes it is clocked only by the programming clock pin
`timescale 1ns/1ns
module debp_device (
	debp_link_if.dev link,
	input wire logic rst_n,
	input wire logic clock_en,
	output logic write_busy,
	output logic upper_address_bit
);
	typedef enum logic [2:0] {st_idle, st_prefix, st_upper, st_data, st_low, st_launch} debp_dstate_t;

	debp_dstate_t state_ff, nxt_state;
	logic [2:0] step_ff, nxt_step;
	logic rd_ff, nxt_rd;
	logic toggle_ff;
	logic upper_ff;
	logic [7:0] low_ff;
	logic [7:0] wdata_ff;
	logic [8:0] paddr_ff;
	logic [3:0] busy_ff;
	logic [7:0] result_ff;
	logic armed_ff;
	logic [7:0] mem [debp_pkg::MEM_DEPTH];

	wire logic clk_link = link.prog_clock_pin;
	wire logic [7:0] bus = link.prog_data_bus;

	// ----------------------------------------------------------------
	// decode of the launch string
	// ----------------------------------------------------------------
	wire logic [7:0] step_byte = (step_ff == 3'h1) ? debp_pkg::LAUNCH_K1 :
		(step_ff == 3'h2) ? debp_pkg::LAUNCH_K2 : debp_pkg::FILL;
	wire logic step0_hit = (bus == debp_pkg::LAUNCH_WR) || (bus == debp_pkg::LAUNCH_RD);
	wire logic step_hit = (step_ff == 3'h0) ? step0_hit : (bus == step_byte);
	wire logic fire = (state_ff == st_launch) && step_hit
		&& (step_ff == debp_pkg::LAUNCH_LAST_STEP);
	wire logic fire_wr = fire && !rd_ff && (busy_ff == 4'h0) && armed_ff;
	wire logic fire_rd = fire && rd_ff;
	wire logic prog_end = (busy_ff == 4'h1);

	// next decoder state from the byte taken on this pulse
	always_comb begin
		nxt_state = st_idle;
		nxt_step = step_ff;
		nxt_rd = rd_ff;
		case (state_ff)
			st_prefix: begin
				if (bus == debp_pkg::SEL_UPPER) begin
					nxt_state = st_upper;
				end else if (bus == debp_pkg::SEL_DATA) begin
					nxt_state = st_data;
				end else if (bus == debp_pkg::SEL_LOW) begin
					nxt_state = st_low;
				end
			end
			st_upper, st_data, st_low: begin
				nxt_state = st_idle;
			end
			st_launch: begin
				if (step_hit && (step_ff != debp_pkg::LAUNCH_LAST_STEP)) begin
					nxt_state = st_launch;
					nxt_step = step_ff + 3'h1;
					if (step_ff == 3'h0) begin
						nxt_rd = (bus == debp_pkg::LAUNCH_RD);
					end
				end
			end
			default: begin
				if (bus == debp_pkg::PREFIX) begin
					nxt_state = st_prefix;
				end else if (bus == debp_pkg::LAUNCH) begin
					nxt_state = st_launch;
					nxt_step = 3'h0;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// state, handshake and latched fields
	// ----------------------------------------------------------------
	// one toggle for every byte sampled on a clock pulse
	always_ff @(posedge clk_link) begin
		if (!rst_n) begin
			state_ff <= st_idle;
			step_ff <= 3'h0;
			rd_ff <= 1'b0;
			toggle_ff <= 1'b0;
		end else if (clock_en) begin
			state_ff <= nxt_state;
			step_ff <= nxt_step;
			rd_ff <= nxt_rd;
			toggle_ff <= ~toggle_ff;
		end
	end

	// address and data fields, upper bit kept across accesses
	always_ff @(posedge clk_link) begin
		if (!rst_n) begin
			upper_ff <= 1'b0;
			low_ff <= 8'h00;
			wdata_ff <= 8'h00;
			armed_ff <= 1'b0;
		end else if (clock_en) begin
			// a launch with no fresh load only polls, so a poll never restarts a write
			if ((state_ff == st_data) || (state_ff == st_low)) begin
				armed_ff <= 1'b1;
			end else if (fire) begin
				armed_ff <= 1'b0;
			end
			if (state_ff == st_upper) begin
				upper_ff <= bus[0];
			end
			if (state_ff == st_data) begin
				wdata_ff <= bus;
			end
			if (state_ff == st_low) begin
				low_ff <= bus;
			end
		end
	end

	// ----------------------------------------------------------------
	// write timer and result port
	// ----------------------------------------------------------------
	// a launch during a running write only polls it
	always_ff @(posedge clk_link) begin
		if (!rst_n) begin
			busy_ff <= 4'h0;
			paddr_ff <= 9'h000;
			result_ff <= debp_pkg::RESULT_RST;
		end else if (clock_en) begin
			if (fire_wr) begin
				busy_ff <= debp_pkg::WRITE_PULSES;
				paddr_ff <= {upper_ff, low_ff};
				result_ff <= debp_pkg::RESULT_RST;
			end else if (busy_ff != 4'h0) begin
				busy_ff <= busy_ff - 4'h1;
			end
			if (prog_end) begin
				result_ff <= debp_pkg::DONE_MASK;
			end else if (fire_rd) begin
				result_ff <= mem[{upper_ff, low_ff}];
			end
		end
	end

	// array store at the end of the write time
	always_ff @(posedge clk_link) begin
		if (clock_en && prog_end) begin
			mem[paddr_ff] <= wdata_ff;
		end
	end

	assign link.handshake_toggle = toggle_ff;
	assign link.result_port = result_ff;
	assign write_busy = (busy_ff != 4'h0);
	assign upper_address_bit = upper_ff;
endmodule : debp_device

module debp_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clock_en,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int unsigned PW = $clog2(DEPTH);

	logic [WIDTH-1:0] buf_mem [DEPTH];
	logic [PW:0] wr_ff;
	logic [PW:0] rd_ff;

	wire logic empty = (wr_ff == rd_ff);
	wire logic full = (wr_ff[PW-1:0] == rd_ff[PW-1:0]) && (wr_ff[PW] != rd_ff[PW]);
	wire logic push = in_valid && !full && clock_en;
	wire logic pop = out_ready && !empty && clock_en;

	// ----------------------------------------------------------------
	// pointers with a wrap bit
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wr_ff <= '0;
			rd_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= rd_ff + 1'b1;
			end
		end
	end

	// storage
	always_ff @(posedge clock) begin
		if (push) begin
			buf_mem[wr_ff[PW-1:0]] <= in_data;
		end
	end

	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = buf_mem[rd_ff[PW-1:0]];
endmodule : debp_fifo

// >>> verilog/debp_programmer.sv
// programmer end: byte sequencer and pulse maker behind a command fifo
// assumes a free 250 MHz clock and the fifo module of the device file
`timescale 1ns/1ns
module debp_programmer (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clock_en,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_read,
	input wire logic [8:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	output logic rsp_valid,
	output logic rsp_read,
	output logic [7:0] rsp_data,
	debp_link_if.prg link
);
	typedef enum logic [2:0] {h_wake, h_idle, h_setup, h_high, h_low, h_check, h_result} debp_hstate_t;

	debp_hstate_t state_ff, nxt_state;
	logic [3:0] idx_ff, nxt_idx;
	logic [7:0] cnt_ff;
	logic [2:0] wake_ff;
	logic [debp_pkg::CMD_W-1:0] cmd_ff;
	logic a8_known_ff;
	logic a8_ff;
	logic base_ff;
	logic pin_ff;
	logic [7:0] bus_ff;
	logic t1_ff, t2_ff, t3_ff, tog_ff;
	logic [7:0] r1_ff, r2_ff, r3_ff, res_ff;
	logic rsp_valid_ff, rsp_read_ff;
	logic [7:0] rsp_data_ff;
	logic q_valid;
	logic [debp_pkg::CMD_W-1:0] q_data;

	localparam logic [7:0] PULSE_LAST = 8'(debp_pkg::PULSE_CYC - 1);

	// ----------------------------------------------------------------
	// command queue
	// ----------------------------------------------------------------
	wire logic take = (state_ff == h_idle) && q_valid;

	debp_fifo #(.WIDTH(debp_pkg::CMD_W), .DEPTH(debp_pkg::FIFO_DEPTH)) u_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.clock_en(clock_en),
		.in_valid(cmd_valid),
		.in_ready(cmd_ready),
		.in_data({cmd_read, cmd_addr, cmd_data}),
		.out_valid(q_valid),
		.out_ready(take),
		.out_data(q_data)
	);

	// ----------------------------------------------------------------
	// byte for each sequence position
	// ----------------------------------------------------------------
	wire logic c_rd = cmd_ff[17];
	wire logic c_a8 = cmd_ff[16];
	wire logic [7:0] c_lo = cmd_ff[15:8];
	wire logic [7:0] c_dat = cmd_ff[7:0];
	wire logic q_a8 = q_data[16];
	wire logic skip_upper = a8_known_ff && (a8_ff == q_a8);
	wire logic toggled = (tog_ff != base_ff);
	wire logic pulse_end = (cnt_ff == PULSE_LAST);
	wire logic done_seen = res_ff[debp_pkg::DONE_BIT];

	// full byte string of a write or a read
	function automatic logic [7:0] seq_byte(input logic [3:0] idx, input logic rd,
		input logic a8, input logic [7:0] lo, input logic [7:0] dat);
		logic [7:0] b;
		b = debp_pkg::FILL;
		case (idx)
			4'h0, 4'h3: b = debp_pkg::PREFIX;
			4'h1: b = debp_pkg::SEL_UPPER;
			4'h2: b = {7'h00, a8};
			4'h4: b = rd ? debp_pkg::SEL_LOW : debp_pkg::SEL_DATA;
			4'h5: b = rd ? lo : dat;
			4'h6: b = rd ? debp_pkg::FILL : debp_pkg::PREFIX;
			4'h7: b = rd ? debp_pkg::FILL : debp_pkg::SEL_LOW;
			4'h8: b = rd ? debp_pkg::FILL : lo;
			4'h9: b = debp_pkg::LAUNCH;
			4'ha: b = rd ? debp_pkg::LAUNCH_RD : debp_pkg::LAUNCH_WR;
			4'hb: b = debp_pkg::LAUNCH_K1;
			4'hc: b = debp_pkg::LAUNCH_K2;
			default: b = debp_pkg::FILL;
		endcase
		return b;
	endfunction : seq_byte

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	// one pulse per pass through high and low, then a handshake check
	always_comb begin
		nxt_state = state_ff;
		nxt_idx = idx_ff;
		case (state_ff)
			h_wake: begin
				nxt_state = h_setup;
			end
			h_idle: begin
				if (q_valid) begin
					nxt_state = h_setup;
					nxt_idx = skip_upper ? debp_pkg::SEQ_AFTER_UPPER : debp_pkg::SEQ_FIRST;
				end
			end
			h_setup: begin
				nxt_state = h_high;
			end
			h_high: begin
				if (pulse_end) begin
					nxt_state = h_low;
				end
			end
			h_low: begin
				if (pulse_end) begin
					nxt_state = h_check;
				end
			end
			h_check: begin
				if (wake_ff != 3'h0) begin
					nxt_state = (wake_ff == 3'h1) ? h_idle : h_high;
				end else if (!toggled) begin
					nxt_state = h_high;
				end else if (idx_ff == debp_pkg::SEQ_LAST) begin
					nxt_state = h_result;
				end else begin
					nxt_state = h_setup;
					nxt_idx = idx_ff + 4'h1;
				end
			end
			h_result: begin
				if (!c_rd && !done_seen) begin
					nxt_state = h_setup;
					nxt_idx = debp_pkg::SEQ_LAUNCH;
				end else begin
					nxt_state = h_idle;
				end
			end
			default: begin
				nxt_state = h_idle;
			end
		endcase
	end

	// state, pulse timer and the bus byte
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_ff <= h_wake;
			idx_ff <= debp_pkg::SEQ_FIRST;
			cnt_ff <= 8'h00;
			pin_ff <= 1'b0;
			bus_ff <= debp_pkg::FILL;
		end else if (clock_en) begin
			state_ff <= nxt_state;
			idx_ff <= nxt_idx;
			cnt_ff <= (nxt_state != state_ff) ? 8'h00 : cnt_ff + 8'h01;
			pin_ff <= (nxt_state == h_high);
			if (wake_ff == 3'h0) begin
				bus_ff <= seq_byte(nxt_idx, c_rd, c_a8, c_lo, c_dat);
			end
		end
	end

	// command latch, stored upper bit, wake-up pulse count
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cmd_ff <= '0;
			a8_known_ff <= 1'b0;
			a8_ff <= 1'b0;
			wake_ff <= debp_pkg::WAKE_PULSES;
			base_ff <= 1'b0;
		end else if (clock_en) begin
			if (take) begin
				cmd_ff <= q_data;
				a8_known_ff <= 1'b1;
				a8_ff <= q_a8;
			end
			if ((state_ff == h_check) && (wake_ff != 3'h0)) begin
				wake_ff <= wake_ff - 3'h1;
			end
			if (nxt_state == h_setup) begin
				base_ff <= tog_ff;
			end
		end
	end

	// ----------------------------------------------------------------
	// pin synchronisers, a level counts once stages two and three agree
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			{t1_ff, t2_ff, t3_ff, tog_ff} <= 4'h0;
			{r1_ff, r2_ff, r3_ff, res_ff} <= 32'h0000_0000;
		end else if (clock_en) begin
			{t1_ff, t2_ff, t3_ff} <= {link.handshake_toggle, t1_ff, t2_ff};
			{r1_ff, r2_ff, r3_ff} <= {link.result_port, r1_ff, r2_ff};
			if (t2_ff == t3_ff) begin
				tog_ff <= t3_ff;
			end
			if (r2_ff == r3_ff) begin
				res_ff <= r3_ff;
			end
		end
	end

	// answer to the user, one cycle per finished command
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rsp_valid_ff <= 1'b0;
			rsp_read_ff <= 1'b0;
			rsp_data_ff <= 8'h00;
		end else if (clock_en) begin
			rsp_valid_ff <= (state_ff == h_result) && (c_rd || done_seen);
			if (state_ff == h_result) begin
				rsp_read_ff <= c_rd;
				rsp_data_ff <= res_ff;
			end
		end
	end

	assign link.prog_clock_pin = pin_ff;
	assign link.prog_data_bus = bus_ff;
	assign rsp_valid = rsp_valid_ff;
	assign rsp_read = rsp_read_ff;
	assign rsp_data = rsp_data_ff;
endmodule : debp_programmer

// >>> sim/debp_monitor.sv
// checker for the byte link between programmer end and device end
// assumes the bench wires it beside the link interface instance
`timescale 1ns/1ns
module debp_monitor (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic link_rst_n,
	input wire logic prog_clock_pin,
	input wire logic [7:0] prog_data_bus,
	input wire logic handshake_toggle,
	input wire logic [7:0] result_port,
	input wire logic write_busy,
	input wire logic upper_address_bit
);
	logic [15:0] hi_ff;
	logic tog_ff;
	logic [47:0] hist_ff;
	logic [3:0] busy_ff;

	// ----------------------------------------------------------------
	// helpers in the programmer clock: pulse width, toggle before rise
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			hi_ff <= 16'h0000;
			tog_ff <= 1'b0;
		end else begin
			hi_ff <= prog_clock_pin ? hi_ff + 16'h0001 : 16'h0000;
			if ($rose(prog_clock_pin)) begin
				tog_ff <= $past(handshake_toggle);
			end
		end
	end

	// ----------------------------------------------------------------
	// helpers in the link clock: last six bytes, busy length
	// ----------------------------------------------------------------
	always_ff @(posedge prog_clock_pin) begin
		if (!link_rst_n) begin
			hist_ff <= 48'h000000000000;
			busy_ff <= 4'h0;
		end else begin
			hist_ff <= {hist_ff[39:0], prog_data_bus};
			busy_ff <= write_busy ? busy_ff + 4'h1 : 4'h0;
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_toggle_flip;
		@(posedge prog_clock_pin) disable iff (!link_rst_n)
		1'b1 |=> handshake_toggle != $past(handshake_toggle);
	endproperty
	property p_toggle_at_rise;
		@(posedge clock) disable iff (!rst_n || !link_rst_n)
		$changed(handshake_toggle) |-> $rose(prog_clock_pin);
	endproperty
	property p_high_time;
		@(posedge clock) disable iff (!rst_n)
		$fell(prog_clock_pin) |-> hi_ff >= 16'(debp_pkg::PULSE_CYC);
	endproperty
	property p_bus_hold;
		@(posedge clock) disable iff (!rst_n)
		prog_clock_pin |-> $stable(prog_data_bus);
	endproperty
	property p_advance;
		@(posedge clock) disable iff (!rst_n)
		$changed(prog_data_bus) |-> handshake_toggle != tog_ff;
	endproperty
	property p_result_src;
		@(posedge prog_clock_pin) disable iff (!link_rst_n)
		$changed(result_port) && result_port != debp_pkg::DONE_MASK
		|-> hist_ff[47:40] == debp_pkg::LAUNCH && hist_ff[31:0] == 32'hf5a00000;
	endproperty
	property p_busy_start;
		@(posedge prog_clock_pin) disable iff (!link_rst_n)
		$rose(write_busy) |-> hist_ff == 48'he5f1f5a00000;
	endproperty
	property p_busy_len;
		@(posedge prog_clock_pin) disable iff (!link_rst_n)
		$fell(write_busy) |-> busy_ff == debp_pkg::WRITE_PULSES && result_port[7];
	endproperty
	property p_upper_set;
		@(posedge prog_clock_pin) disable iff (!link_rst_n)
		hist_ff[23:8] == 16'h75f1 && hist_ff[7:1] == 7'h00 |-> upper_address_bit == hist_ff[0];
	endproperty
	property p_upper_keep;
		@(posedge prog_clock_pin) disable iff (!link_rst_n)
		$changed(upper_address_bit) |-> hist_ff[23:8] == 16'h75f1;
	endproperty

	a_toggle_flip: assert property (p_toggle_flip) else $error("toggle held");
	a_toggle_at_rise: assert property (p_toggle_at_rise) else $error("toggle off edge");
	a_high_time: assert property (p_high_time) else $error("pulse too short");
	a_bus_hold: assert property (p_bus_hold) else $error("bus moved in pulse");
	a_advance: assert property (p_advance) else $error("bus moved before flip");
	a_result_src: assert property (p_result_src) else $error("result off launch");
	a_busy_start: assert property (p_busy_start) else $error("busy without launch");
	a_busy_len: assert property (p_busy_len) else $error("write time wrong");
	a_upper_set: assert property (p_upper_set) else $error("upper bit not stored");
	a_upper_keep: assert property (p_upper_keep) else $error("upper bit lost");

	// main scenarios seen
	c_write: cover property (@(posedge prog_clock_pin) $rose(write_busy));
	c_upper: cover property (@(posedge prog_clock_pin) $changed(upper_address_bit));
	c_read: cover property (@(posedge prog_clock_pin) $changed(result_port) && !result_port[7]);
endmodule : debp_monitor

// >>> sim/tb_data_eeprom_byte_prog_port.sv
// bench: programmer end and device end joined over the link
// assumes the programmer end makes the link clock from the 250 MHz clock
`timescale 1ns/1ns
module tb_data_eeprom_byte_prog_port;
	typedef struct packed {
		logic rd;
		logic [8:0] addr;
		logic [7:0] data;
		logic [7:0] exp;
	} debp_row_t;
	localparam int LIMIT = 90000;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic link_rst_n = 1'b0;
	logic run_en = 1'b1;
	logic cmd_valid = 1'b0;
	logic cmd_read = 1'b0;
	logic [8:0] cmd_addr = 9'h000;
	logic [7:0] cmd_data = 8'h00;
	logic [7:0] hold_pin = 8'h00;
	logic [7:0] hold_bus = 8'h00;
	logic cmd_ready;
	logic rsp_valid;
	logic rsp_read;
	logic [7:0] rsp_data;
	logic write_busy;
	logic upper_address_bit;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	int acc = 0;
	debp_row_t rows [4] = '{'{1'b0, 9'h005, 8'ha5, 8'h80}, '{1'b0, 9'h1fe, 8'h3c, 8'h80},
		'{1'b1, 9'h1fe, 8'h00, 8'h3c}, '{1'b1, 9'h005, 8'h00, 8'ha5}};

	// ----------------------------------------------------------------
	// clock, link and the two ends
	// ----------------------------------------------------------------
	always #2 clock = ~clock;
	debp_link_if link_if ();
	debp_device i_debp_device (
		.link(link_if),
		.rst_n(link_rst_n),
		.clock_en(run_en),
		.write_busy(write_busy),
		.upper_address_bit(upper_address_bit)
	);
	debp_programmer i_debp_programmer (
		.clock(clock),
		.rst_n(rst_n),
		.clock_en(run_en),
		.cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready),
		.cmd_read(cmd_read),
		.cmd_addr(cmd_addr),
		.cmd_data(cmd_data),
		.rsp_valid(rsp_valid),
		.rsp_read(rsp_read),
		.rsp_data(rsp_data),
		.link(link_if)
	);
	debp_monitor i_debp_monitor (
		.clock(clock),
		.rst_n(rst_n),
		.link_rst_n(link_rst_n),
		.prog_clock_pin(link_if.prog_clock_pin),
		.prog_data_bus(link_if.prog_data_bus),
		.handshake_toggle(link_if.handshake_toggle),
		.result_port(link_if.result_port),
		.write_busy(write_busy),
		.upper_address_bit(upper_address_bit)
	);

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude

	// one command in, held until the queue takes it
	task automatic push(input debp_row_t r);
		@(negedge clock);
		cmd_valid = 1'b1;
		cmd_read = r.rd;
		cmd_addr = r.addr;
		cmd_data = r.data;
		while (cmd_ready !== 1'b1) begin
			@(negedge clock);
		end
		@(negedge clock);
		cmd_valid = 1'b0;
	endtask : push

	// wait for the answer pulse and compare it
	task automatic await_rsp(input debp_row_t r);
		@(negedge clock);
		while (rsp_valid !== 1'b1) begin
			@(negedge clock);
		end
		check({7'h00, rsp_read}, {7'h00, r.rd});
		check(rsp_data, r.exp);
		check({7'h00, upper_address_bit}, {7'h00, r.addr[8]});
	endtask : await_rsp

	// cuts a hang short
	always @(posedge clock) begin
		cycles++;
		if (cycles == LIMIT) begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, cycles, LIMIT);
			conclude();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(negedge clock);
		rst_n = 1'b1;
		repeat (3) @(posedge link_if.prog_clock_pin);
		@(negedge clock);
		link_rst_n = 1'b1;
		check(link_if.result_port, debp_pkg::RESULT_RST);
		check({7'h00, write_busy}, 8'h00);
		$display("test reset done");
		foreach (rows[i]) begin
			push(rows[i]);
			await_rsp(rows[i]);
			$display("test row %0d done", i);
		end
		// fill the queue until it refuses
		@(negedge clock);
		cmd_valid = 1'b1;
		cmd_read = 1'b1;
		cmd_addr = 9'h005;
		repeat (10) begin
			if (cmd_ready === 1'b1) begin
				acc++;
			end
			@(negedge clock);
		end
		cmd_valid = 1'b0;
		check({7'h00, cmd_ready}, 8'h00);
		check({7'h00, acc >= 8}, 8'h01);
		await_rsp(rows[3]);
		$display("test queue full done");
		// flush by reset in mid transfer, then the link must recover
		@(negedge clock);
		rst_n = 1'b0;
		repeat (12) @(negedge clock);
		check({7'h00, cmd_ready}, 8'h01);
		rst_n = 1'b1;
		push(rows[2]);
		// freeze both ends in mid transfer, the link pins must hold still
		repeat (3000) @(negedge clock);
		run_en = 1'b0;
		hold_pin = {7'h00, link_if.prog_clock_pin};
		hold_bus = link_if.prog_data_bus;
		repeat (600) @(negedge clock);
		check({7'h00, link_if.prog_clock_pin}, hold_pin);
		check(link_if.prog_data_bus, hold_bus);
		run_en = 1'b1;
		await_rsp(rows[2]);
		$display("test reset recovery done");
		conclude();
	end
endmodule : tb_data_eeprom_byte_prog_port
